// [common/mpurc_pkg.sv]
// shared constants for the region protection configuration and control block
package mpurc_pkg;

  // ***************************************************************
  // register byte addresses on the private peripheral bus
  // ***************************************************************
  localparam logic [31:0] MPURC_TYPE_ADDR = 32'hE000ED90;
  localparam logic [31:0] MPURC_CTRL_ADDR = 32'hE000ED94;
  localparam logic [31:0] MPURC_SEL_ADDR = 32'hE000ED98;
  localparam logic [31:0] MPURC_BASE_ADDR = 32'hE000ED9C;
  localparam logic [31:0] MPURC_ATTR_ADDR = 32'hE000EDA0;
  localparam logic [31:0] MPURC_BASE_A1_ADDR = 32'hE000EDA4;
  localparam logic [31:0] MPURC_ATTR_A1_ADDR = 32'hE000EDA8;
  localparam logic [31:0] MPURC_BASE_A2_ADDR = 32'hE000EDAC;
  localparam logic [31:0] MPURC_ATTR_A2_ADDR = 32'hE000EDB0;
  localparam logic [31:0] MPURC_BASE_A3_ADDR = 32'hE000EDB4;
  localparam logic [31:0] MPURC_ATTR_A3_ADDR = 32'hE000EDB8;

  // ***************************************************************
  // reset and fixed read values
  // ***************************************************************
  localparam logic [31:0] MPURC_TYPE_VALUE = 32'h00000800;
  localparam logic [31:0] MPURC_CTRL_RESET = 32'h00000800;
  localparam logic [31:0] MPURC_SEL_RESET = 32'h00000800;
  localparam logic [31:0] MPURC_BASE_RESET = 32'h00000000;
  localparam logic [31:0] MPURC_ATTR_RESET = 32'h00000000;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int MPURC_CTRL_ENABLE_BIT = 0;
  localparam int MPURC_CTRL_HANDLER_BIT = 1;
  localparam int MPURC_CTRL_BACKGROUND_BIT = 2;
  localparam int MPURC_BASE_VALID_BIT = 4;
  localparam int MPURC_BASE_LSB = 5;
  localparam int MPURC_ATTR_EXECUTE_NEVER_BIT = 28;
  localparam int MPURC_ATTR_ACCESS_PERMISSION_LSB = 24;
  localparam int MPURC_ATTR_TYPE_EXTENSION_LSB = 19;
  localparam int MPURC_ATTR_S_BIT = 18;
  localparam int MPURC_ATTR_C_BIT = 17;
  localparam int MPURC_ATTR_B_BIT = 16;
  localparam int MPURC_ATTR_SUBREGION_DISABLE_LSB = 8;
  localparam int MPURC_ATTR_SIZE_LSB = 1;
  localparam int MPURC_ATTR_EN_BIT = 0;
  // bits of the attribute/size word that hold state; the rest read zero
  localparam logic [31:0] MPURC_ATTR_MASK = 32'h173FFF3F;

  // ***************************************************************
  // size encodings and system control space window
  // ***************************************************************
  localparam logic [4:0] MPURC_SIZE_MIN = 5'h04;
  localparam logic [4:0] MPURC_SIZE_SUB_MIN = 5'h07;
  localparam logic [4:0] MPURC_SIZE_FULL = 5'h1F;
  localparam logic [31:0] MPURC_SCS_BASE = 32'hE000E000;
  localparam logic [31:0] MPURC_SCS_MASK = 32'hFFFFF000;

endpackage

// [rtl/mpurc_top.sv]
// region protection configuration registers and access checker
`timescale 1ns/100ps
// Functional notes
// - protection off: every access uses the default map; only control space fetches fault
// - on without background: access missing every enabled region faults
// - on with background: privileged misses use default map, regions win
// - on with background: unprivileged misses still fault
// - background bit has no effect while protection is off
// - priority -1/-2 handlers bypass protection unless handler bit set
// - control space and vectors always allowed; control space never executable
// - eight regions; selector takes only 0-7 and steers base/attribute access
// - base write with valid loads selector from region field, else uses selector
// - valid bit of base register reads zero
// - region field of base register reads the selector
// - base is bits 31:N, N = log2 size, aligned to size
// - 4 GB region covers everything with base zero
// - size is 2^(field+1); encodings 4 to 31 valid
// - attribute/size register takes word and halfword writes
// - execute-never regions block instruction fetches
// - set subregion-disable bit removes that subregion from the match
// - only enabled regions take part in matching
// - 256-byte-plus regions split into eight subregions, lsb lowest
// - three alias pairs behave like the primary base/attribute registers
module mpurc_top
  import mpurc_pkg::*;
#(
  parameter int REGIONS = 8
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // private peripheral bus slave
  input wire logic ppb_req_in,
  input wire logic ppb_write_in,
  input wire logic [31:0] ppb_addr_in,
  input wire logic [31:0] ppb_wdata_in,
  input wire logic [3:0] ppb_strb_in,
  output logic ppb_ready_out,
  output logic ppb_error_out,
  output logic [31:0] ppb_rdata_out,
  // access check request from load/store and fetch paths
  input wire logic chk_valid_in,
  input wire logic [31:0] chk_addr_in,
  input wire logic chk_priv_in,
  input wire logic chk_fetch_in,
  input wire logic chk_escalated_in,
  input wire logic chk_vector_in,
  // access check result, one cycle after the request
  output logic chk_valid_out,
  output logic chk_fault_out,
  output logic chk_hit_out,
  output logic [2:0] chk_region_out,
  output logic chk_background_out,
  output logic chk_bypass_out,
  output logic chk_strongly_ordered_out,
  output logic chk_execute_never_out,
  output logic [2:0] chk_access_permission_out,
  output logic [2:0] chk_type_extension_out,
  output logic chk_s_out,
  output logic chk_c_out,
  output logic chk_b_out
);

  // ***************************************************************
  // address decode helpers
  // ***************************************************************

  // base register and its three aliases
  function automatic logic mpurc_is_base(input logic [31:0] a);
    return (a == MPURC_BASE_ADDR) || (a == MPURC_BASE_A1_ADDR) ||
           (a == MPURC_BASE_A2_ADDR) || (a == MPURC_BASE_A3_ADDR);
  endfunction

  // attribute/size register and its three aliases
  function automatic logic mpurc_is_attr(input logic [31:0] a);
    return (a == MPURC_ATTR_ADDR) || (a == MPURC_ATTR_A1_ADDR) ||
           (a == MPURC_ATTR_A2_ADDR) || (a == MPURC_ATTR_A3_ADDR);
  endfunction

  // ***************************************************************
  // register state
  // ***************************************************************
  // control bits, selector and the per-region words; the selector is three
  // bits wide so it can never index past the last region
  logic enable_r;
  logic handler_protection_enable_r;
  logic privileged_background_enable_r;
  logic [2:0] region_selector_r;
  logic [26:0] base_r [REGIONS];
  logic [31:0] attr_r [REGIONS];

  // write qualifiers shared by the register processes
  logic wr_word;
  logic wr_any;
  logic base_valid;
  logic [3:0] base_region;
  logic [31:0] attr_wmask;

  // word writes only, except the attribute register which takes lanes
  assign wr_word = ppb_req_in && ppb_write_in && (ppb_strb_in == 4'hF);
  assign wr_any = ppb_req_in && ppb_write_in;
  assign base_valid = ppb_wdata_in[MPURC_BASE_VALID_BIT];
  assign base_region = ppb_wdata_in[3:0];
  assign attr_wmask = {{8{ppb_strb_in[3]}}, {8{ppb_strb_in[2]}},
                       {8{ppb_strb_in[1]}}, {8{ppb_strb_in[0]}}} & MPURC_ATTR_MASK;

  // control bits; reserved bits of the reset word are not stored
  // partial-strobe writes are dropped here, only word access is legal
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enable_r <= MPURC_CTRL_RESET[MPURC_CTRL_ENABLE_BIT];
      handler_protection_enable_r <= MPURC_CTRL_RESET[MPURC_CTRL_HANDLER_BIT];
      privileged_background_enable_r <= MPURC_CTRL_RESET[MPURC_CTRL_BACKGROUND_BIT];
    end else if (wr_word && ppb_addr_in == MPURC_CTRL_ADDR) begin
      enable_r <= ppb_wdata_in[MPURC_CTRL_ENABLE_BIT];
      handler_protection_enable_r <= ppb_wdata_in[MPURC_CTRL_HANDLER_BIT];
      privileged_background_enable_r <= ppb_wdata_in[MPURC_CTRL_BACKGROUND_BIT];
    end
  end

  // selector: direct write or base write with valid; values above 7 dropped
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      region_selector_r <= MPURC_SEL_RESET[2:0];
    end else if (wr_word && ppb_addr_in == MPURC_SEL_ADDR) begin
      if (ppb_wdata_in[31:3] == 29'h0) begin
        region_selector_r <= ppb_wdata_in[2:0];
      end
    end else if (wr_word && mpurc_is_base(ppb_addr_in) && base_valid) begin
      if (!base_region[3]) begin
        region_selector_r <= base_region[2:0];
      end
    end
  end

  // per-region base and attribute storage
  generate
    for (genvar g = 0; g < REGIONS; g++) begin : g_store
      logic base_hit_sel;
      // target is the written region field when valid, else the selector
      assign base_hit_sel = base_valid ? (base_region == 4'(g))
                                       : (region_selector_r == 3'(g));

      always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          base_r[g] <= MPURC_BASE_RESET[31:MPURC_BASE_LSB];
        end else if (wr_word && mpurc_is_base(ppb_addr_in) && base_hit_sel) begin
          base_r[g] <= ppb_wdata_in[31:MPURC_BASE_LSB];
        end
      end

      // byte lanes merge so halfword writes leave the other half alone
      always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          attr_r[g] <= MPURC_ATTR_RESET;
        end else if (wr_any && mpurc_is_attr(ppb_addr_in) &&
                     region_selector_r == 3'(g)) begin
          attr_r[g] <= (attr_r[g] & ~attr_wmask) | (ppb_wdata_in & attr_wmask);
        end
      end
    end
  endgenerate

  // ***************************************************************
  // read path and bus answer
  // ***************************************************************
  // read mux output and unmapped-address flag
  logic [31:0] rd_nxt;
  logic err_nxt;
  logic [31:0] sel_base_word;

  // valid bit reads zero, region field shows the selector
  assign sel_base_word = {base_r[region_selector_r], 2'b00, region_selector_r};

  // decode; unmapped addresses answer with an error and zero data
  always_comb begin
    rd_nxt = 32'h00000000;
    err_nxt = 1'b0;
    if (ppb_addr_in == MPURC_TYPE_ADDR) begin
      rd_nxt = MPURC_TYPE_VALUE;
    end else if (ppb_addr_in == MPURC_CTRL_ADDR) begin
      rd_nxt = {29'h0, privileged_background_enable_r,
                handler_protection_enable_r, enable_r};
    end else if (ppb_addr_in == MPURC_SEL_ADDR) begin
      rd_nxt = {29'h0, region_selector_r};
    end else if (mpurc_is_base(ppb_addr_in)) begin
      rd_nxt = sel_base_word;
    end else if (mpurc_is_attr(ppb_addr_in)) begin
      rd_nxt = attr_r[region_selector_r];
    end else begin
      err_nxt = 1'b1;
    end
  end

  // single-cycle answer: one ready pulse per request, error only when unmapped
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ppb_ready_out <= 1'b0;
      ppb_error_out <= 1'b0;
    end else begin
      ppb_ready_out <= ppb_req_in;
      ppb_error_out <= ppb_req_in && err_nxt;
    end
  end

  // read data held until the next read so a late master can still take it
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ppb_rdata_out <= 32'h00000000;
    end else if (ppb_req_in && !ppb_write_in) begin
      ppb_rdata_out <= rd_nxt;
    end
  end

  // ***************************************************************
  // region matching
  // ***************************************************************
  // one match bit per region; overlapping regions may all match at once
  logic [REGIONS-1:0] match;

  generate
    for (genvar g = 0; g < REGIONS; g++) begin : g_match
      logic [4:0] size;
      logic [31:0] addr_mask;
      logic [31:0] sub_shift;
      logic [2:0] sub_idx;
      logic base_ok;
      logic sub_ok;

      assign size = attr_r[g][MPURC_ATTR_SIZE_LSB +: 5];
      // 4 GB keeps no base bits and matches every address
      assign addr_mask = (size == MPURC_SIZE_FULL) ? 32'h00000000
                         : ~((32'h00000001 << (size + 5'd1)) - 32'h00000001);
      assign base_ok = ((chk_addr_in ^ {base_r[g], 5'h00}) & addr_mask) == 32'h0;
      // subregion number is the top three offset bits inside the region
      assign sub_shift = chk_addr_in >> (size - 5'd2);
      assign sub_idx = sub_shift[2:0];
      // small regions ignore the disable field; software keeps it zero there
      assign sub_ok = (size < MPURC_SIZE_SUB_MIN) ||
                      !attr_r[g][MPURC_ATTR_SUBREGION_DISABLE_LSB + sub_idx];
      // encodings below the minimum never match
      assign match[g] = attr_r[g][MPURC_ATTR_EN_BIT] && (size >= MPURC_SIZE_MIN) &&
                        base_ok && sub_ok;
    end
  endgenerate

  // highest numbered matching region wins an overlap
  // loop runs upward so the last match seen, the highest, is kept
  logic any_hit;
  logic [2:0] hit_idx;

  always_comb begin
    any_hit = 1'b0;
    hit_idx = 3'h0;
    for (int i = 0; i < REGIONS; i++) begin
      if (match[i]) begin
        any_hit = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  // ***************************************************************
  // access decision
  // ***************************************************************
  // decision terms, all combinational from the request of this cycle
  logic in_scs;
  logic bypass;
  logic background;
  logic hit_execute_never;
  logic fault_nxt;

  // control space window is fixed; the vector table flag comes from the core
  assign in_scs = (chk_addr_in & MPURC_SCS_MASK) == MPURC_SCS_BASE;
  // protection off, or escalated handler without handler protection
  // the handler bit never turns checking on by itself: software keeps it
  // clear while protection is off
  assign bypass = !enable_r ||
                  (chk_escalated_in && !handler_protection_enable_r);
  // execute-never of the winning region only; lower overlapping regions do not vote
  assign hit_execute_never = attr_r[hit_idx][MPURC_ATTR_EXECUTE_NEVER_BIT];
  // background only for privileged misses with the background bit set
  assign background = !bypass && !any_hit && chk_priv_in &&
                      privileged_background_enable_r;

  // control space fetches fault even while bypassed
  always_comb begin
    fault_nxt = 1'b0;
    if (in_scs && chk_fetch_in) begin
      fault_nxt = 1'b1;
    end else if (bypass || in_scs || chk_vector_in) begin
      fault_nxt = 1'b0;
    end else if (any_hit) begin
      fault_nxt = chk_fetch_in && hit_execute_never;
    end else begin
      fault_nxt = !background;
    end
  end

  // result strobe follows the request by exactly one cycle
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chk_valid_out <= 1'b0;
    end else begin
      chk_valid_out <= chk_valid_in;
    end
  end

  // result fields from flip-flops, held between requests so a stalled
  // consumer can still read them late
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chk_fault_out <= 1'b0;
      chk_hit_out <= 1'b0;
      chk_region_out <= 3'h0;
      chk_background_out <= 1'b0;
      chk_bypass_out <= 1'b0;
      chk_strongly_ordered_out <= 1'b0;
      chk_execute_never_out <= 1'b0;
      chk_access_permission_out <= 3'h0;
      chk_type_extension_out <= 3'h0;
      chk_s_out <= 1'b0;
      chk_c_out <= 1'b0;
      chk_b_out <= 1'b0;
    end else if (chk_valid_in) begin
      chk_fault_out <= fault_nxt;
      chk_hit_out <= !bypass && any_hit;
      chk_region_out <= hit_idx;
      chk_background_out <= background;
      chk_bypass_out <= bypass;
      chk_strongly_ordered_out <= in_scs;
      chk_execute_never_out <= in_scs || (!bypass && any_hit && hit_execute_never);
      // attributes of the winning region for the permission checker
      chk_access_permission_out <= attr_r[hit_idx][MPURC_ATTR_ACCESS_PERMISSION_LSB +: 3];
      chk_type_extension_out <= attr_r[hit_idx][MPURC_ATTR_TYPE_EXTENSION_LSB +: 3];
      chk_s_out <= attr_r[hit_idx][MPURC_ATTR_S_BIT];
      chk_c_out <= attr_r[hit_idx][MPURC_ATTR_C_BIT];
      chk_b_out <= attr_r[hit_idx][MPURC_ATTR_B_BIT];
    end
  end

endmodule

// [bench/mpurc_core_model.sv]
// processor core model issuing load/store and fetch access checks
`timescale 1ns/100ps
module mpurc_core_model (
  input wire logic mclk_in,
  output logic chk_valid_out,
  output logic [31:0] chk_addr_out,
  output logic [3:0] chk_kind_out
);
  // quiet until the first request; kind is {priv, fetch, escalated, vector}
  initial {chk_valid_out, chk_addr_out, chk_kind_out} = '0;
  // one request held a single cycle; idle cycles first give slow traffic
  task automatic access(input logic [31:0] a, input logic [3:0] k, input int idle);
    repeat (idle) @(posedge mclk_in);
    @(posedge mclk_in);
    {chk_valid_out, chk_addr_out, chk_kind_out} <= {1'b1, a, k};
    @(posedge mclk_in);
    // stale fields flip so a dropped request never looks live
    {chk_valid_out, chk_addr_out, chk_kind_out} <= {1'b0, ~a, ~k};
  endtask
endmodule

// [bench/mpurc_top_chk.sv]
// concurrent checks on the region protection block ports
`timescale 1ns/100ps
module mpurc_chk import mpurc_pkg::*; #(parameter int REGIONS = 8) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic ppb_req_in,
  input wire logic ppb_write_in,
  input wire logic [31:0] ppb_addr_in,
  input wire logic [31:0] ppb_wdata_in,
  input wire logic ppb_ready_out,
  input wire logic ppb_error_out,
  input wire logic [31:0] ppb_rdata_out,
  input wire logic chk_valid_in,
  input wire logic [31:0] chk_addr_in,
  input wire logic chk_priv_in,
  input wire logic chk_fetch_in,
  input wire logic chk_escalated_in,
  input wire logic chk_vector_in,
  input wire logic chk_valid_out,
  input wire logic chk_fault_out,
  input wire logic chk_hit_out,
  input wire logic chk_bypass_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  logic en_r, hnd_r, bg_r;
  wire xf = chk_fetch_in && (chk_addr_in & MPURC_SCS_MASK) == MPURC_SCS_BASE;
  wire scs = (chk_addr_in & MPURC_SCS_MASK) == MPURC_SCS_BASE;
  wire bad_a = ppb_addr_in < MPURC_TYPE_ADDR || ppb_addr_in > MPURC_ATTR_A3_ADDR
    || |ppb_addr_in[1:0];
  wire prot = chk_valid_in && en_r && !(chk_escalated_in && !hnd_r);
  // shadow control bits; full-word writes only, as the bench issues them
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) {bg_r, hnd_r, en_r} <= 3'h0;
    else if (ppb_req_in && ppb_write_in && ppb_addr_in == MPURC_CTRL_ADDR)
      {bg_r, hnd_r, en_r} <= ppb_wdata_in[2:0];
  end
  sequence s_base_rd;
    ppb_req_in && !ppb_write_in && ppb_addr_in == MPURC_BASE_ADDR ##1 ppb_ready_out;
  endsequence
  property p_answer; ppb_req_in |=> ppb_ready_out; endproperty
  a_answer: assert property (p_answer) else $error("bus request unanswered");
  property p_unmapped; ppb_req_in && bad_a |=> ppb_error_out && ppb_ready_out; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  property p_valid_rd; s_base_rd |-> !ppb_rdata_out[MPURC_BASE_VALID_BIT]; endproperty
  a_valid_rd: assert property (p_valid_rd) else $error("valid bit read back");
  property p_off; chk_valid_in && !en_r && !xf |=> chk_bypass_out && !chk_fault_out; endproperty
  a_off: assert property (p_off) else $error("check while disabled");
  property p_hnd;
    chk_valid_in && en_r && chk_escalated_in && !hnd_r && !xf |=> chk_bypass_out && !chk_fault_out;
  endproperty
  a_hnd: assert property (p_hnd) else $error("handler not bypassed");
  property p_scs; chk_valid_in && xf |=> chk_valid_out && chk_fault_out; endproperty
  a_scs: assert property (p_scs) else $error("control space fetch allowed");
  property p_miss;
    prot && !scs && !chk_vector_in && !(chk_priv_in && bg_r) |=> chk_hit_out || chk_fault_out;
  endproperty
  a_miss: assert property (p_miss) else $error("miss without fault");
  property p_bg; prot && bg_r && chk_priv_in && !chk_fetch_in |=> !chk_fault_out; endproperty
  a_bg: assert property (p_bg) else $error("background access faulted");
endmodule
// attach the checker to every instance of the block
bind mpurc_top mpurc_chk #(.REGIONS(REGIONS)) u_chk (.mclk_in(mclk_in),
  .reset_n_in(reset_n_in), .ppb_req_in(ppb_req_in), .ppb_write_in(ppb_write_in),
  .ppb_addr_in(ppb_addr_in), .ppb_wdata_in(ppb_wdata_in), .ppb_ready_out(ppb_ready_out),
  .ppb_error_out(ppb_error_out), .ppb_rdata_out(ppb_rdata_out),
  .chk_valid_in(chk_valid_in), .chk_addr_in(chk_addr_in), .chk_priv_in(chk_priv_in),
  .chk_fetch_in(chk_fetch_in), .chk_escalated_in(chk_escalated_in),
  .chk_vector_in(chk_vector_in), .chk_valid_out(chk_valid_out),
  .chk_fault_out(chk_fault_out), .chk_hit_out(chk_hit_out), .chk_bypass_out(chk_bypass_out));

// [bench/mpurc_top_test.sv]
// self-checking bench for the region protection block
`timescale 1ns/100ps
module mpurc_top_test;
  import mpurc_pkg::*;
  localparam logic [3:0] PR = 4'h8, FE = 4'h4, ES = 4'h2, VE = 4'h1, NO = 4'h0;
  localparam logic [1:0] OK = 2'h0, HIT = 2'h1, FLT = 2'h2, FH = 2'h3;
  localparam logic WR = 1'b1, RD = 1'b0;
  logic mclk_in, reset_n_in, ppb_req_in, ppb_write_in, ppb_ready_out, ppb_error_out;
  logic [31:0] ppb_addr_in, ppb_wdata_in, chk_addr_in, ppb_rdata_out;
  logic [3:0] ppb_strb_in;
  logic chk_valid_in, chk_priv_in, chk_fetch_in, chk_escalated_in, chk_vector_in;
  logic chk_valid_out, chk_fault_out, chk_hit_out, chk_background_out, chk_bypass_out;
  logic chk_strongly_ordered_out, chk_execute_never_out, chk_s_out, chk_c_out, chk_b_out;
  logic [2:0] chk_region_out, chk_access_permission_out, chk_type_extension_out;
  logic [3:0] chk_kind;
  int miscompares = 0;
  int n_tests = 0;
  // block and the core-side request model
  mpurc_top #(.REGIONS(8)) dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .ppb_req_in(ppb_req_in), .ppb_write_in(ppb_write_in), .ppb_addr_in(ppb_addr_in),
    .ppb_wdata_in(ppb_wdata_in), .ppb_strb_in(ppb_strb_in), .ppb_ready_out(ppb_ready_out),
    .ppb_error_out(ppb_error_out), .ppb_rdata_out(ppb_rdata_out),
    .chk_valid_in(chk_valid_in), .chk_addr_in(chk_addr_in), .chk_priv_in(chk_priv_in),
    .chk_fetch_in(chk_fetch_in), .chk_escalated_in(chk_escalated_in),
    .chk_vector_in(chk_vector_in), .chk_valid_out(chk_valid_out),
    .chk_fault_out(chk_fault_out), .chk_hit_out(chk_hit_out),
    .chk_region_out(chk_region_out), .chk_background_out(chk_background_out),
    .chk_bypass_out(chk_bypass_out), .chk_strongly_ordered_out(chk_strongly_ordered_out),
    .chk_execute_never_out(chk_execute_never_out),
    .chk_access_permission_out(chk_access_permission_out),
    .chk_type_extension_out(chk_type_extension_out), .chk_s_out(chk_s_out),
    .chk_c_out(chk_c_out), .chk_b_out(chk_b_out));
  mpurc_core_model u_core (.mclk_in(mclk_in), .chk_valid_out(chk_valid_in),
    .chk_addr_out(chk_addr_in), .chk_kind_out(chk_kind));
  // kind is {priv, fetch, escalated, vector}
  assign {chk_priv_in, chk_fetch_in, chk_escalated_in, chk_vector_in} = chk_kind;
  // core clock, 8 ns period
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single-cycle request pulse; d is write data, or expected data on reads
  task automatic bus(input logic w, input logic [31:0] a, d, input logic e = 1'b0,
                     input logic [3:0] s = 4'hF);
    @(posedge mclk_in);
    {ppb_req_in, ppb_write_in, ppb_addr_in, ppb_wdata_in, ppb_strb_in} <= {1'b1, w, a, d, s};
    @(posedge mclk_in);
    ppb_req_in <= 1'b0;
    #1;
    cmp({30'h0, ppb_ready_out, ppb_error_out}, {30'h0, 1'b1, e});
    if (!w) cmp(ppb_rdata_out, d);
  endtask
  // one access check; x is {fault, hit}
  task automatic acc(input logic [31:0] a, input logic [3:0] m, input logic [1:0] x,
                     input int n = 0);
    u_core.access(a, m, n);
    #1;
    cmp({29'h0, chk_valid_out, chk_fault_out, chk_hit_out}, {29'h0, 1'b1, x});
  endtask
  task automatic t_regs;
    bus(RD, MPURC_TYPE_ADDR, 32'h00000800);
    bus(RD, MPURC_CTRL_ADDR, 32'h0);
    bus(RD, 32'hE000EDBC, 32'h0, 1'b1);
    bus(WR, MPURC_BASE_ADDR, 32'h40000015);
    bus(RD, MPURC_BASE_ADDR, 32'h40000005);
    bus(WR, MPURC_BASE_A1_ADDR, 32'h50000002);
    bus(WR, MPURC_SEL_ADDR, 32'h8);
    bus(RD, MPURC_SEL_ADDR, 32'h5);
    bus(RD, MPURC_BASE_ADDR, 32'h50000005);
    bus(WR, MPURC_ATTR_ADDR, 32'h05030012, 1'b0, 4'h3);
    bus(RD, MPURC_ATTR_A2_ADDR, 32'h00000012);
  endtask
  task automatic t_prot;
    bus(WR, MPURC_BASE_ADDR, 32'h20000010);
    bus(WR, MPURC_ATTR_ADDR, 32'h10000013);
    bus(WR, MPURC_BASE_ADDR, 32'h30000011);
    bus(WR, MPURC_ATTR_ADDR, 32'h00000113);
    bus(WR, MPURC_CTRL_ADDR, 32'h4);
    acc(32'h10000000, NO, OK);
    bus(WR, MPURC_CTRL_ADDR, 32'h1);
    acc(32'h10000000, PR, FLT);
    acc(32'h20000004, FE, FH);
    cmp({30'h0, chk_strongly_ordered_out, chk_execute_never_out}, 32'h1);
    acc(32'h30000000, PR, FLT);
    acc(32'h30000080, NO, HIT, 3);
    acc(32'h50000000, PR, FLT);
    acc(32'hE000E100, FE, FLT);
    cmp({30'h0, chk_strongly_ordered_out, chk_execute_never_out}, 32'h3);
    acc(32'h00000000, VE, OK);
    acc(32'h10000000, ES, OK);
    cmp({31'h0, chk_bypass_out}, 32'h1);
    bus(WR, MPURC_CTRL_ADDR, 32'h3);
    acc(32'h10000000, ES, FLT);
    bus(WR, MPURC_CTRL_ADDR, 32'h5);
    acc(32'h10000000, PR, OK);
    cmp({30'h0, chk_background_out, chk_bypass_out}, 32'h2);
    acc(32'h20000004, PR, HIT);
    acc(32'h10000000, NO, FLT);
    cmp({31'h0, chk_background_out}, 32'h0);
  endtask
  task automatic t_size;
    bus(WR, MPURC_BASE_ADDR, 32'h70000036);
    bus(WR, MPURC_ATTR_ADDR, 32'h00000009);
    acc(32'h7000003C, NO, HIT);
    acc(32'h7000001C, NO, FLT);
    bus(WR, MPURC_BASE_ADDR, 32'h12345677);
    bus(WR, MPURC_ATTR_ADDR, 32'h030F003F);
    acc(32'h90000000, NO, HIT);
    cmp({20'h0, chk_region_out, chk_access_permission_out, chk_type_extension_out,
         chk_s_out, chk_c_out, chk_b_out}, 32'h00000ECF);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset, then the scenarios in order
  initial begin
    reset_n_in = 1'b0;
    {ppb_req_in, ppb_write_in, ppb_addr_in, ppb_wdata_in, ppb_strb_in} = '0;
    repeat (20) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    t_regs();
    t_prot();
    t_size();
    summarize();
  end
  // watchdog; the run needs about a hundred cycles, so 20 us means a hang
  initial begin
    #20us;
    miscompares++;
    summarize();
  end
endmodule
